//--- phase_dir_pkg.sv
// Constants and carrier types for the phase overcurrent directional supervision block
package phase_dir_pkg;

  // Timing
  localparam int unsigned     CLK_PERIOD_NS = 4;
  localparam longint unsigned MEM_HOLD_NS   = 64'd1_000_000_000;
  localparam int unsigned     MEM_HOLD_CYC  = int'(MEM_HOLD_NS / CLK_PERIOD_NS);
  localparam logic [1:0]      DLY_TICKS     = 2'h2;

  // Angles in whole degrees
  localparam logic [10:0] ANG_FULL = 11'h168;
  localparam logic [10:0] ANG_HALF = 11'h0b4;
  localparam logic [10:0] ANG_QTR  = 11'h05a;
  localparam logic [10:0] ANG_3QTR = 11'h10e;
  localparam logic [8:0]  ANG_MAX  = 9'h167;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_ANGLE   = 8'h04;
  localparam logic [7:0] ADDR_PICKUP0 = 8'h08;
  localparam logic [7:0] ADDR_STRIDE  = 8'h04;
  localparam logic [7:0] ADDR_MINPOL  = 8'h18;
  localparam logic [7:0] ADDR_VNOM    = 8'h1c;
  localparam logic [7:0] ADDR_STATUS  = 8'h20;

  // Control field positions
  localparam int unsigned CTRL_RESTRAINT_BIT = 0;
  localparam int unsigned CTRL_BOE_BIT       = 1;
  localparam int unsigned CTRL_ACB_BIT       = 2;
  localparam int unsigned CTRL_VT_LSB        = 3;
  localparam int unsigned CTRL_DIR_LSB       = 8;
  localparam int unsigned CTRL_EN_LSB        = 16;
  localparam logic [31:0] CTRL_MASK          = 32'h000f_ff1f;

  // Status field positions
  localparam int unsigned STAT_FWD_LSB   = 0;
  localparam int unsigned STAT_POL_LSB   = 4;
  localparam int unsigned STAT_LIVE_LSB  = 8;
  localparam int unsigned STAT_RSTR_BIT  = 12;
  localparam int unsigned STAT_OP_LSB    = 16;

  // Reset values and limits
  localparam logic [31:0] CTRL_RST    = 32'h0000_0008;
  localparam logic [8:0]  ANGLE_RST   = 9'h01e;
  localparam logic [11:0] PICKUP_RST  = 12'h064;
  localparam logic [11:0] PICKUP_MIN  = 12'h005;
  localparam logic [11:0] PICKUP_MAX  = 12'h7d0;
  localparam logic [15:0] MINPOL_RST  = 16'h0064;
  localparam logic [15:0] VNOM_RST    = 16'h2710;
  localparam logic [1:0]  VT_NONE     = 2'h0;

  // Direction setting of one element group
  typedef enum logic [1:0] {DIR_OFF, DIR_FWD, DIR_REV} dir_mode_t;

  // Phasors from the measurement front end, index 0..2 = A,B,C or AB,BC,CA
  typedef struct packed {
    logic [2:0][15:0] i_mag;
    logic [2:0][8:0]  i_ang;
    logic [2:0][15:0] vph_mag;
    logic [2:0][15:0] vll_mag;
    logic [2:0][8:0]  vll_ang;
  } meas_t;

  // Element outputs, group 0..1 time, 2..3 instantaneous
  typedef struct packed {
    logic [3:0][2:0] operate;
  } ops_t;

endpackage

//--- phase_directional_supervision.sv
// Phase overcurrent elements with directional supervision, voltage memory and restraint
`timescale 1ns/1ps

module phase_directional_supervision #(
  parameter int unsigned MEM_HOLD_CYCLES = phase_dir_pkg::MEM_HOLD_CYC
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire phase_dir_pkg::meas_t meas,
  input  wire logic                 cycle_tick,
  input  wire logic                 prot_ctrl_active,
  output phase_dir_pkg::ops_t       trip,
  output logic      [2:0]           dir_forward,
  output logic      [2:0]           pol_valid
);

  localparam int unsigned CW = $clog2(MEM_HOLD_CYCLES + 1);

  logic [31:0]      ctrl_q;
  logic [8:0]       angle_q;
  logic [11:0]      pickup_q [4];
  logic [15:0]      minpol_q;
  logic [15:0]      vnom_q;
  logic             pready_q;
  logic             pslverr_q;
  logic [31:0]      prdata_q;
  logic             setup;
  logic             wr_ok;
  logic             reject;
  logic [31:0]      rd_word;
  logic [2:0]       pk_idx;
  logic             restraint_on;
  logic             block_exp;
  logic             acb;
  logic [3:0][2:0]  over_d;
  logic [3:0][2:0]  over_q;
  logic [3:0][2:0]  op_d;
  logic [2:0]       live_d;
  logic [2:0]       live_q;
  logic [2:0]       fwd_d;
  logic [2:0]       fwd_q;
  logic [2:0]       pol_ok_d;
  logic [2:0]       pol_ok_q;
  phase_dir_pkg::ops_t trip_q;

  // Address of a pickup register
  function automatic logic [7:0] pickup_addr(input int unsigned k);
    return phase_dir_pkg::ADDR_PICKUP0 + 8'(k * phase_dir_pkg::ADDR_STRIDE);
  endfunction

  // Pickup register index, 4 when none
  function automatic logic [2:0] pickup_idx(input logic [7:0] a);
    logic [2:0] r;
    r = 3'h4;
    for (int k = 0; k < 4; k++) begin
      if (a == pickup_addr(k)) begin
        r = 3'(k);
      end
    end
    return r;
  endfunction

  // Forward zone test on the angle of current against the torque line
  function automatic logic fwd_zone(input logic [8:0] ai, input logic [8:0] av,
                                    input logic half, input logic [8:0] max_torque_angle);
    logic [10:0] d;
    d = 11'(ai) + 11'(3 * phase_dir_pkg::ANG_FULL) - 11'(av) - 11'(max_torque_angle);
    if (half) begin
      d = d - phase_dir_pkg::ANG_HALF;
    end
    for (int k = 0; k < 3; k++) begin
      if (d >= phase_dir_pkg::ANG_FULL) begin
        d = d - phase_dir_pkg::ANG_FULL;
      end
    end
    return (d < phase_dir_pkg::ANG_QTR) || (d > phase_dir_pkg::ANG_3QTR);
  endfunction

  // Restraint availability
  // transformer type gate
  assign restraint_on = ctrl_q[phase_dir_pkg::CTRL_RESTRAINT_BIT] &&
                        (ctrl_q[phase_dir_pkg::CTRL_VT_LSB +: 2] != phase_dir_pkg::VT_NONE);
  assign block_exp    = ctrl_q[phase_dir_pkg::CTRL_BOE_BIT];
  assign acb          = ctrl_q[phase_dir_pkg::CTRL_ACB_BIT];

  assign pk_idx = pickup_idx(paddr);
  assign setup = psel && !penable;
  assign wr_ok = psel && penable && pwrite && pready_q && !pslverr_q;

  // Request check during setup
  always_comb begin
    reject = 1'b0;
    if (paddr == phase_dir_pkg::ADDR_CTRL) begin
      reject = 1'b0;
    end else if (paddr == phase_dir_pkg::ADDR_ANGLE) begin
      reject = pwrite && (pwdata > 32'(phase_dir_pkg::ANG_MAX));
    end else if (pk_idx != 3'h4) begin
      reject = pwrite && ((pwdata < 32'(phase_dir_pkg::PICKUP_MIN)) ||
                          (pwdata > 32'(phase_dir_pkg::PICKUP_MAX)));
      if (pwrite && !pk_idx[1] && restraint_on && prot_ctrl_active) begin
        reject = 1'b1;
      end
    end else if (paddr == phase_dir_pkg::ADDR_MINPOL) begin
      reject = 1'b0;
    end else if (paddr == phase_dir_pkg::ADDR_VNOM) begin
      reject = 1'b0;
    end else if (paddr == phase_dir_pkg::ADDR_STATUS) begin
      reject = pwrite;
    end else begin
      reject = 1'b1;
    end
  end

  // Read data selection
  always_comb begin
    rd_word = 32'h0000_0000;
    if (paddr == phase_dir_pkg::ADDR_CTRL) begin
      rd_word = ctrl_q;
    end else if (paddr == phase_dir_pkg::ADDR_ANGLE) begin
      rd_word = 32'(angle_q);
    end else if (pk_idx != 3'h4) begin
      rd_word = 32'(pickup_q[pk_idx[1:0]]);
    end else if (paddr == phase_dir_pkg::ADDR_MINPOL) begin
      rd_word = 32'(minpol_q);
    end else if (paddr == phase_dir_pkg::ADDR_VNOM) begin
      rd_word = 32'(vnom_q);
    end else if (paddr == phase_dir_pkg::ADDR_STATUS) begin
      rd_word[phase_dir_pkg::STAT_FWD_LSB +: 3]  = fwd_q;
      rd_word[phase_dir_pkg::STAT_POL_LSB +: 3]  = pol_ok_q;
      rd_word[phase_dir_pkg::STAT_LIVE_LSB +: 3] = live_q;
      rd_word[phase_dir_pkg::STAT_RSTR_BIT]      = restraint_on;
      rd_word[phase_dir_pkg::STAT_OP_LSB +: 12]  = trip_q.operate;
    end else begin
      rd_word = 32'h0000_0000;
    end
  end

  // Bus answer, one cycle after setup
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup && reject;
      if (setup && !pwrite) begin
        prdata_q <= rd_word;
      end
    end
  end

  // Control register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= phase_dir_pkg::CTRL_RST;
    end else if (wr_ok && paddr == phase_dir_pkg::ADDR_CTRL) begin
      ctrl_q <= pwdata & phase_dir_pkg::CTRL_MASK;
    end
  end

  // Torque angle setting
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      angle_q <= phase_dir_pkg::ANGLE_RST;
    end else if (wr_ok && paddr == phase_dir_pkg::ADDR_ANGLE) begin
      angle_q <= pwdata[8:0];
    end
  end

  // Pickup settings
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < 4; k++) begin
        pickup_q[k] <= phase_dir_pkg::PICKUP_RST;
      end
    end else begin
      for (int k = 0; k < 4; k++) begin
        if (wr_ok && paddr == pickup_addr(k)) begin
          pickup_q[k] <= pwdata[11:0];
        end
      end
    end
  end

  // Voltage thresholds
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      minpol_q <= phase_dir_pkg::MINPOL_RST;
      vnom_q   <= phase_dir_pkg::VNOM_RST;
    end else begin
      if (wr_ok && paddr == phase_dir_pkg::ADDR_MINPOL) begin
        minpol_q <= pwdata[15:0];
      end
      if (wr_ok && paddr == phase_dir_pkg::ADDR_VNOM) begin
        vnom_q <= pwdata[15:0];
      end
    end
  end

  // Per phase direction and voltage memory
  for (genvar p = 0; p < 3; p++) begin : g_phase
    localparam int unsigned POL = (p + 1) % 3;
    logic [8:0]    mem_ang_q;
    logic [CW-1:0] mem_cnt_q;
    logic [8:0]    ang_use;

    assign live_d[p]   = meas.vll_mag[POL] >= minpol_q;
    // stored angle when live too low
    assign ang_use     = live_d[p] ? meas.vll_ang[POL] : mem_ang_q;
    assign fwd_d[p]    = fwd_zone(meas.i_ang[p], ang_use, acb, angle_q);
    assign pol_ok_d[p] = live_d[p] || (mem_cnt_q != '0);

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        mem_ang_q <= 9'h000;
        mem_cnt_q <= '0;
      end else if (live_d[p]) begin
        mem_ang_q <= meas.vll_ang[POL];
        mem_cnt_q <= CW'(MEM_HOLD_CYCLES);
      end else if (mem_cnt_q != '0) begin
        mem_cnt_q <= mem_cnt_q - 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      live_q   <= 3'h0;
      fwd_q    <= 3'h0;
      pol_ok_q <= 3'h0;
    end else begin
      live_q   <= live_d;
      fwd_q    <= fwd_d;
      pol_ok_q <= pol_ok_d;
    end
  end

  // Element groups: 0..1 time, 2..3 instantaneous
  // four groups, two time and two instantaneous
  for (genvar g = 0; g < 4; g++) begin : g_group
    phase_dir_pkg::dir_mode_t dir_mode;
    assign dir_mode = phase_dir_pkg::dir_mode_t'(ctrl_q[phase_dir_pkg::CTRL_DIR_LSB + 2*g +: 2]);

    for (genvar p = 0; p < 3; p++) begin : g_elem
      logic [15:0] i_now;
      logic [15:0] v_eff;
      logic [31:0] lhs;
      logic [31:0] rhs;
      logic        perm;
      logic        qual;
      logic [1:0]  dly_q;

      assign i_now = meas.i_mag[p];
      assign v_eff = (meas.vph_mag[p] < vnom_q) ? meas.vph_mag[p] : vnom_q;
      assign lhs   = 32'(i_now) * 32'(vnom_q);
      assign rhs   = 32'(pickup_q[g]) * 32'(v_eff);

      if (g < 2) begin : g_time
        always_comb begin
          if (restraint_on) begin
            over_d[g][p] = (i_now >= 16'(phase_dir_pkg::PICKUP_MIN)) && (lhs >= rhs);
          end else begin
            over_d[g][p] = i_now >= 16'(pickup_q[g]);
          end
        end
      end else begin : g_inst
        assign over_d[g][p] = i_now >= 16'(pickup_q[g]);
      end

      // Direction permission from live or stored voltage
      always_comb begin
        if (pol_ok_q[p]) begin
          perm = (dir_mode == phase_dir_pkg::DIR_FWD) ? fwd_q[p] : !fwd_q[p];
        end else begin
          perm = !block_exp;
        end
      end

      assign qual = ctrl_q[phase_dir_pkg::CTRL_EN_LSB + g] && over_q[g][p] &&
                    ((dir_mode == phase_dir_pkg::DIR_OFF) || perm);

      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          dly_q <= 2'h0;
        end else if (!qual) begin
          dly_q <= 2'h0;
        end else if (cycle_tick && dly_q != phase_dir_pkg::DLY_TICKS) begin
          dly_q <= dly_q + 2'h1;
        end
      end

      assign op_d[g][p] = qual && ((dir_mode == phase_dir_pkg::DIR_OFF) ||
                                   (dly_q == phase_dir_pkg::DLY_TICKS));
    end
  end

  // Element outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      over_q         <= '0;
      trip_q.operate <= '0;
    end else begin
      over_q         <= over_d;
      trip_q.operate <= op_d;
    end
  end

  assign prdata      = prdata_q;
  assign pready      = pready_q;
  assign pslverr     = pslverr_q;
  assign trip        = trip_q;
  assign dir_forward = fwd_q;
  assign pol_valid   = pol_ok_q;

endmodule

//--- phase_dir_sva.sv
// Concurrent checks on the ports of the phase directional supervision block
`timescale 1ns/1ps
module phase_dir_sva #(
  parameter int unsigned MEM_HOLD_CYCLES = phase_dir_pkg::MEM_HOLD_CYC
) (
  input wire logic                 clk,
  input wire logic                 rst_n,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [7:0]           paddr,
  input wire logic [31:0]          pwdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire phase_dir_pkg::meas_t meas,
  input wire logic                 prot_ctrl_active,
  input wire phase_dir_pkg::ops_t  trip,
  input wire logic [2:0]           dir_forward,
  input wire logic [2:0]           pol_valid
);
  logic [31:0] ctrl_q;
  logic [15:0] low_q;
  logic        live_q;
  logic [1:0]  up_q;
  wire         setup = psel && !penable && up_q == 2'h3;
  wire         wsel  = setup && pwrite;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ctrl_q <= phase_dir_pkg::CTRL_RST;
    else if (psel && penable && pready && !pslverr && pwrite && paddr == 8'h00)
      ctrl_q <= pwdata & phase_dir_pkg::CTRL_MASK;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_q  <= 16'h0000;
      live_q <= 1'b0;
    end else if (meas.vll_mag[1] > phase_dir_pkg::MINPOL_RST) begin
      low_q  <= 16'h0000;
      live_q <= up_q == 2'h3;
    end else if (low_q != 16'hffff) low_q <= low_q + 16'h0001;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_answer;
    pready ##1 !pready;
  endsequence

  a_ready_pulse: assert property (setup |=> s_answer)
    else $error("pready is not a one cycle answer");
  a_angle_range: assert property (
    wsel && paddr == 8'h04 |=> pready && pslverr == (pwdata > 32'h0000_0167))
    else $error("angle write refusal wrong");
  a_pickup_floor: assert property (
    wsel && paddr inside {8'h08, 8'h0c, 8'h10, 8'h14} && pwdata < 32'h0000_0005 |=> pslverr)
    else $error("pickup below floor accepted");
  a_pickup_lock: assert property (
    wsel && paddr inside {8'h08, 8'h0c} && ctrl_q[0] && ctrl_q[4:3] != 2'h0
    && prot_ctrl_active |=> pready && pslverr)
    else $error("time pickup changed while locked");
  a_vt_none_free: assert property (
    wsel && paddr == 8'h08 && ctrl_q[4:3] == 2'h0
    && pwdata inside {[32'h0000_0005:32'h0000_07d0]} |=> pready && !pslverr)
    else $error("pickup refused with no bus transformer");
  a_live_valid: assert property (
    up_q == 2'h3 && meas.vll_mag[1] > phase_dir_pkg::MINPOL_RST |=> pol_valid[0])
    else $error("live polarizing voltage not valid");
  a_mem_hold: assert property (
    live_q && low_q + 3 <= MEM_HOLD_CYCLES |-> pol_valid[0])
    else $error("voltage memory lost too early");
  a_mem_expire: assert property (
    low_q >= MEM_HOLD_CYCLES + 3 |-> !pol_valid[0])
    else $error("voltage memory held too long");
  a_dir_permit: assert property (
    $rose(trip.operate[0][0]) && ctrl_q[9:8] != 2'h0 && pol_valid[0]
    |-> $past(dir_forward[0]) == (ctrl_q[9:8] == 2'h1))
    else $error("time element operated against direction");
endmodule

bind phase_directional_supervision phase_dir_sva #(.MEM_HOLD_CYCLES(MEM_HOLD_CYCLES)) i_sva (
  .clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .meas,
  .prot_ctrl_active, .trip, .dir_forward, .pol_valid);

//--- meas_source.sv
// Measurement front end model: registered phasors and a power-cycle tick
`timescale 1ns/1ps
module meas_source #(
  parameter int unsigned TICK_CYC = 16
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire phase_dir_pkg::meas_t m_set,
  output phase_dir_pkg::meas_t      meas,
  output logic                      cycle_tick
);
  int unsigned cnt_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) meas <= '0;
    else meas <= m_set;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q      <= 0;
      cycle_tick <= 1'b0;
    end else begin
      cnt_q      <= (cnt_q == TICK_CYC - 1) ? 0 : cnt_q + 1;
      cycle_tick <= cnt_q == TICK_CYC - 1;
    end
  end
endmodule

//--- phase_directional_supervision_test.sv
// Self-checking bench for the phase directional supervision block
`timescale 1ns/1ps
module phase_directional_supervision_test;
  localparam int MEM = 50;
  localparam int TK  = 16;
  logic                 clk = 1'b0;
  logic                 rst_n = 1'b0;
  logic                 psel = 1'b0;
  logic                 penable = 1'b0;
  logic                 pwrite = 1'b0;
  logic [7:0]           paddr = 8'h00;
  logic [31:0]          pwdata = 32'h0000_0000;
  logic                 prot_ctrl_active = 1'b0;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  logic                 cycle_tick;
  logic [2:0]           dir_forward;
  logic [2:0]           pol_valid;
  phase_dir_pkg::meas_t m_set;
  phase_dir_pkg::meas_t meas;
  phase_dir_pkg::ops_t  trip;
  int                   failures = 0;
  int                   n_checks = 0;
  int                   seed = 32'h33d7_4318;
  int                   cyc = 0;

  always #2 clk = ~clk;

  phase_directional_supervision #(.MEM_HOLD_CYCLES(MEM)) i_dut (.clk, .rst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .meas, .cycle_tick,
    .prot_ctrl_active, .trip, .dir_forward, .pol_valid);
  meas_source #(.TICK_CYC(TK)) i_src (.clk, .rst_n, .m_set, .meas, .cycle_tick);

  task automatic close_out;
    if (failures == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      close_out();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      failures++;
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] x, input logic xe);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    chk("pslverr", {31'h0, xe}, {31'h0, pslverr});
    if (!w) chk("prdata", x, prdata);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic setm(input logic [15:0] im, input logic [8:0] ia, input logic [15:0] vm);
    phase_dir_pkg::meas_t m;
    m = m_set;
    for (int p = 0; p < 3; p++) begin
      m.i_mag[p]   = im;
      m.i_ang[p]   = ia;
      m.vll_mag[p] = vm;
      m.vph_mag[p] = vm;
      m.vll_ang[p] = 9'h000;
    end
    @(posedge clk);
    m_set <= m;
  endtask

  function automatic logic [2:0] exp_fwd(input phase_dir_pkg::meas_t m, input int a,
                                         input logic acb);
    int d;
    for (int p = 0; p < 3; p++) begin
      d = (int'(m.i_ang[p]) - int'(m.vll_ang[(p + 1) % 3]) - (acb ? 180 : 0) - a + 1080) % 360;
      exp_fwd[p] = d < 90 || d > 270;
    end
  endfunction

  task automatic trip_is(input logic [11:0] e);
    chk("trip", {20'h0, e}, {20'h0, trip});
  endtask

  initial begin
    phase_dir_pkg::meas_t m;
    int                   a;
    logic                 acb;
    m_set = '0;
    setm(16'h0000, 9'h000, 16'h2710);
    repeat (11) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, 8'h00, 32'h0, phase_dir_pkg::CTRL_RST, 1'b0);
    apb(1'b0, 8'h04, 32'h0, 32'h0000_001e, 1'b0);
    apb(1'b0, 8'h08, 32'h0, 32'h0000_0064, 1'b0);
    apb(1'b0, 8'h40, 32'h0, 32'h0000_0000, 1'b1);
    apb(1'b1, 8'h20, 32'h0000_0001, 32'h0, 1'b1);
    apb(1'b1, 8'h04, 32'h0000_0168, 32'h0, 1'b1);
    apb(1'b1, 8'h0c, 32'h0000_0004, 32'h0, 1'b1);
    apb(1'b1, 8'h0c, 32'h0000_07d1, 32'h0, 1'b1);
    apb(1'b1, 8'h00, 32'h0000_0009, 32'h0, 1'b0);
    prot_ctrl_active <= 1'b1;
    apb(1'b1, 8'h08, 32'h0000_00c8, 32'h0, 1'b1);
    apb(1'b1, 8'h10, 32'h0000_00c8, 32'h0, 1'b0);
    apb(1'b0, 8'h08, 32'h0, 32'h0000_0064, 1'b0);
    apb(1'b1, 8'h00, 32'h0000_0001, 32'h0, 1'b0);
    apb(1'b1, 8'h08, 32'h0000_0064, 32'h0, 1'b0);
    prot_ctrl_active <= 1'b0;
    for (int k = 0; k < 24; k++) begin
      a   = (k < 2) ? k * 359 : int'({$random(seed)} % 32'd360);
      acb = 1'($random(seed));
      m   = m_set;
      for (int p = 0; p < 3; p++) begin
        m.i_ang[p]   = 9'({$random(seed)} % 32'd360);
        m.vll_ang[p] = 9'({$random(seed)} % 32'd360);
      end
      apb(1'b1, 8'h00, {29'h0000_0001, acb, 2'h0}, 32'h0, 1'b0);
      apb(1'b1, 8'h04, 32'(a), 32'h0, 1'b0);
      m_set <= m;
      repeat (4) @(posedge clk);
      chk("dir_forward", {29'h0, exp_fwd(m, a, acb)}, {29'h0, dir_forward});
    end
    apb(1'b1, 8'h04, 32'h0000_001e, 32'h0, 1'b0);
    apb(1'b1, 8'h00, 32'h000f_0008, 32'h0, 1'b0);
    setm(16'h01f4, 9'h01e, 16'h2710);
    repeat (4) @(posedge clk);
    trip_is(12'hfff);
    m_set.i_mag[1] <= 16'h0000;
    repeat (4) @(posedge clk);
    trip_is(12'hb6d);
    setm(16'h0000, 9'h01e, 16'h2710);
    repeat (4) @(posedge clk);
    apb(1'b1, 8'h00, 32'h0001_0108, 32'h0, 1'b0);
    setm(16'h01f4, 9'h01e, 16'h2710);
    repeat (5) @(posedge clk);
    trip_is(12'h000);
    repeat (3 * TK) @(posedge clk);
    trip_is(12'h007);
    apb(1'b1, 8'h00, 32'h0001_0208, 32'h0, 1'b0);
    repeat (4) @(posedge clk);
    trip_is(12'h000);
    setm(16'h01f4, 9'h0d2, 16'h2710);
    repeat (3 * TK) @(posedge clk);
    trip_is(12'h007);
    apb(1'b1, 8'h00, 32'h0001_0308, 32'h0, 1'b0);
    setm(16'h01f4, 9'h01e, 16'h2710);
    repeat (4) @(posedge clk);
    trip_is(12'h000);
    setm(16'h01f4, 9'h0d2, 16'h2710);
    repeat (3 * TK) @(posedge clk);
    trip_is(12'h007);
    apb(1'b1, 8'h00, 32'h0001_020a, 32'h0, 1'b0);
    setm(16'h01f4, 9'h0d2, 16'h0000);
    repeat (MEM / 2) @(posedge clk);
    chk("pol_valid", 32'h7, {29'h0, pol_valid});
    trip_is(12'h007);
    repeat (MEM + 10) @(posedge clk);
    chk("pol_valid", 32'h0, {29'h0, pol_valid});
    trip_is(12'h000);
    apb(1'b1, 8'h00, 32'h0001_0208, 32'h0, 1'b0);
    setm(16'h01f4, 9'h01e, 16'h0000);
    repeat (3 * TK) @(posedge clk);
    trip_is(12'h007);
    setm(16'h01f4, 9'h01e, 16'h2710);
    repeat (4) @(posedge clk);
    chk("pol_valid", 32'h7, {29'h0, pol_valid});
    repeat (4) @(posedge clk);
    trip_is(12'h000);
    apb(1'b1, 8'h00, 32'h0001_0009, 32'h0, 1'b0);
    setm(16'h003c, 9'h01e, 16'h1388);
    repeat (4) @(posedge clk);
    trip_is(12'h007);
    apb(1'b1, 8'h00, 32'h0001_0001, 32'h0, 1'b0);
    repeat (4) @(posedge clk);
    trip_is(12'h000);
    apb(1'b0, 8'h20, 32'h0, 32'h0000_0777, 1'b0);
    close_out();
  end
endmodule
